/* src/ipsw_core.sv */
// Interrupt priority flags, program status word and its stack handling.
// Assumes the CPU core sequences instructions and owns the stack pointer and memory.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps

// Operation
// R1: Each source's level is formed from its bit in the level-0 and level-1 registers.
// R2: All priority flag registers are read/write and reset to all ones.
// R3: The status word holds the global enable flag and two in-service level flags.
// R4: The status word takes 8-bit reads and writes, single-bit writes, and enable/disable.
// R5: Interrupt acceptance or break saves the status word to the stack and clears the enable.
// R6: Accepting a maskable request copies its two priority bits into the in-service flags.
// R7: Both return instructions and pop-status-word reload the status word from the stack.
// R8: Reset loads the status word with 06H.
// R9: Push-status-word writes the word at SP-1, a zero byte at SP-2, and lowers SP by two.
// R10: Pop-status-word loads the word from SP+1, raises SP by two, and takes three clocks.
// R11: A maskable request is taken only when enabled and above the in-service level.
module ipsw_core
    import ipsw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_SRC-1:0] irq_req,
    input wire ipsw_cmd_s cmd,
    input wire logic [ADDR_W-1:0] stack_pointer,
    input wire logic [7:0] stack_rdata,
    output ipsw_stack_s stack_access,
    output logic sp_load,
    output logic [ADDR_W-1:0] sp_next,
    output logic [7:0] program_status_word,
    output logic irq_pending,
    output logic [SRC_W-1:0] irq_source,
    output logic [1:0] irq_level,
    output logic busy,
    output logic done
);

    logic [7:0] prio0_low_q;
    logic [7:0] prio0_high_q;
    logic [7:0] prio1_low_q;
    logic [7:0] prio1_high_q;
    logic [7:0] psw_q;
    logic [7:0] psw_d;
    logic [7:0] rdata_q;
    logic [NUM_SRC-1:0] req_meta_q;
    logic [NUM_SRC-1:0] req_sync_q;
    ipsw_state_e state_q;
    ipsw_state_e state_d;
    ipsw_stack_s stack_q;
    ipsw_stack_s stack_d;
    logic sp_load_q;
    logic sp_load_d;
    logic [ADDR_W-1:0] sp_next_q;
    logic [ADDR_W-1:0] sp_next_d;
    logic [ADDR_W-1:0] sp_base_q;
    logic done_q;
    logic done_d;
    logic pend_q;
    logic [SRC_W-1:0] src_q;
    logic [1:0] lvl_q;
    logic [NUM_SRC-1:0] prio_bit0;
    logic [NUM_SRC-1:0] prio_bit1;
    logic [NUM_SRC-1:0] eligible;
    logic [1:0] level [NUM_SRC];
    logic sel_found;
    logic [SRC_W-1:0] sel_src;
    logic [1:0] sel_lvl;
    logic pop_load;
    logic save_event;

    // Request lines come from outside the clock's domain.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_meta_q <= '0;
            req_sync_q <= '0;
        end else begin
            req_meta_q <= irq_req;
            req_sync_q <= req_meta_q;
        end
    end

    // Priority flag register writes.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prio0_low_q <= PRIORITY_RESET; // R2
            prio0_high_q <= PRIORITY_RESET; // R2
            prio1_low_q <= PRIORITY_RESET; // R2
            prio1_high_q <= PRIORITY_RESET; // R2
        end else if (reg_wr) begin
            if (reg_addr == PRIORITY_LEVEL0_LOW_ADDR) begin
                prio0_low_q <= reg_wdata; // R2
            end else if (reg_addr == PRIORITY_LEVEL0_HIGH_ADDR) begin
                prio0_high_q <= reg_wdata; // R2
            end else if (reg_addr == PRIORITY_LEVEL1_LOW_ADDR) begin
                prio1_low_q <= reg_wdata; // R2
            end else if (reg_addr == PRIORITY_LEVEL1_HIGH_ADDR) begin
                prio1_high_q <= reg_wdata; // R2
            end
        end
    end

    // Register read data stands in the cycle after the read strobe only.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= UNMAPPED_READ;
        end else if (reg_rd) begin
            if (reg_addr == PRIORITY_LEVEL0_LOW_ADDR) begin
                rdata_q <= prio0_low_q; // R2
            end else if (reg_addr == PRIORITY_LEVEL0_HIGH_ADDR) begin
                rdata_q <= prio0_high_q; // R2
            end else if (reg_addr == PRIORITY_LEVEL1_LOW_ADDR) begin
                rdata_q <= prio1_low_q; // R2
            end else if (reg_addr == PRIORITY_LEVEL1_HIGH_ADDR) begin
                rdata_q <= prio1_high_q; // R2
            end else if (reg_addr == PROGRAM_STATUS_WORD_ADDR) begin
                rdata_q <= psw_q; // R4
            end else begin
                rdata_q <= UNMAPPED_READ;
            end
        end else begin
            rdata_q <= UNMAPPED_READ;
        end
    end

    assign prio_bit0 = {prio0_high_q, prio0_low_q};
    assign prio_bit1 = {prio1_high_q, prio1_low_q};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            ipsw_src_level u_level (
                .req(req_sync_q[gi]),
                .prio_bit0(prio_bit0[gi]),
                .prio_bit1(prio_bit1[gi]),
                .irq_enable(psw_q[PSW_IE_BIT]),
                .in_service_level({psw_q[PSW_IN_SERVICE_LEVEL_BIT1_BIT], psw_q[PSW_IN_SERVICE_LEVEL_BIT0_BIT]}),
                .level(level[gi]),
                .eligible(eligible[gi])
            );
        end
    endgenerate

    // Lowest level number wins; among equals, the lowest source index wins.
    always_comb begin
        sel_found = 1'b0;
        sel_src = '0;
        sel_lvl = 2'h3;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i] && (!sel_found || level[i] <= sel_lvl)) begin
                sel_found = 1'b1;
                sel_src = SRC_W'(i);
                sel_lvl = level[i];
            end
        end
    end

    // The offer is withdrawn while the sequencer saves, pushes or pops the status word; a restore strobe does not withdraw it.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= 1'b0;
            src_q <= '0;
            lvl_q <= 2'h3;
        end else begin
            pend_q <= sel_found && (state_d == IPSW_IDLE) && !save_event; // R11
            src_q <= sel_src;
            lvl_q <= sel_lvl;
        end
    end

    assign save_event = cmd.maskable_accept || cmd.vectored_accept || cmd.break_instruction;
    assign pop_load = (state_q == IPSW_POP_LD);

    // Status word update; stack reloads take precedence over acceptance and instructions.
    always_comb begin
        psw_d = psw_q;
        if (pop_load) begin
            psw_d = stack_rdata; // R10
        end else if (cmd.status_restore) begin
            psw_d = cmd.restore_data; // R7
        end else if (save_event) begin
            psw_d[PSW_IE_BIT] = 1'b0; // R5
            if (cmd.maskable_accept) begin
                psw_d[PSW_IN_SERVICE_LEVEL_BIT1_BIT] = lvl_q[1]; // R6
                psw_d[PSW_IN_SERVICE_LEVEL_BIT0_BIT] = lvl_q[0]; // R6
            end
        end else if (cmd.enable_irq_instruction) begin
            psw_d[PSW_IE_BIT] = 1'b1; // R4
        end else if (cmd.disable_irq_instruction) begin
            psw_d[PSW_IE_BIT] = 1'b0; // R4
        end else if (cmd.psw_write) begin
            psw_d = cmd.psw_wdata; // R4
        end else if (cmd.bit_write) begin
            psw_d[cmd.bit_index] = cmd.bit_value; // R4
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            psw_q <= PSW_RESET; // R8
        end else begin
            psw_q <= psw_d; // R3
        end
    end

    // Stack sequencer for save, push and pop of the status word.
    always_comb begin
        state_d = state_q;
        stack_d = '0;
        sp_load_d = 1'b0;
        sp_next_d = sp_next_q;
        done_d = 1'b0;
        case (state_q)
            IPSW_IDLE: begin
                if (save_event) begin
                    stack_d.wr = 1'b1; // R5
                    stack_d.addr = stack_pointer - SP_ONE; // R5
                    stack_d.wdata = psw_q; // R5
                    state_d = IPSW_SAVE_DONE;
                end else if (cmd.push_status_instruction) begin
                    stack_d.wr = 1'b1; // R9
                    stack_d.addr = stack_pointer - SP_ONE; // R9
                    stack_d.wdata = psw_q; // R9
                    state_d = IPSW_PUSH_LO;
                end else if (cmd.pop_status_instruction) begin
                    state_d = IPSW_POP_RD; // R10
                end
            end
            IPSW_PUSH_LO: begin
                stack_d.wr = 1'b1; // R9
                stack_d.addr = sp_base_q - SP_TWO; // R9
                stack_d.wdata = PUSH_FILL_BYTE; // R9
                sp_load_d = 1'b1; // R9
                sp_next_d = sp_base_q - SP_TWO; // R9
                done_d = 1'b1;
                state_d = IPSW_IDLE;
            end
            IPSW_POP_RD: begin
                stack_d.rd = 1'b1; // R10
                stack_d.addr = sp_base_q + SP_ONE; // R10
                state_d = IPSW_POP_LD;
            end
            IPSW_POP_LD: begin
                sp_load_d = 1'b1; // R10
                sp_next_d = sp_base_q + SP_TWO; // R10
                done_d = 1'b1;
                state_d = IPSW_IDLE;
            end
            IPSW_SAVE_DONE: begin
                done_d = 1'b1;
                state_d = IPSW_IDLE;
            end
            default: begin
                state_d = IPSW_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= IPSW_IDLE;
            sp_base_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == IPSW_IDLE) begin
                sp_base_q <= stack_pointer;
            end
        end
    end

    // Stack and stack-pointer outputs are registered one cycle behind the sequencer.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_q <= '0;
            sp_load_q <= 1'b0;
            sp_next_q <= '0;
            done_q <= 1'b0;
        end else begin
            stack_q <= stack_d;
            sp_load_q <= sp_load_d;
            sp_next_q <= sp_next_d;
            done_q <= done_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign stack_access = stack_q;
    assign sp_load = sp_load_q;
    assign sp_next = sp_next_q;
    assign program_status_word = psw_q;
    assign irq_pending = pend_q;
    assign irq_source = src_q;
    assign irq_level = lvl_q;
    assign busy = (state_q != IPSW_IDLE);
    assign done = done_q;

endmodule // ipsw_core

/* src/ipsw_pkg.sv */
// Package for the interrupt priority and status-word block.
// Assumes a CPU core with a 20-bit byte address space and an 8-bit status word.
package ipsw_pkg;

    localparam int ADDR_W = 20;
    localparam int NUM_SRC = 16;
    localparam int SRC_W = 4;

    // Priority flag registers at their byte addresses.
    localparam logic [ADDR_W-1:0] PRIORITY_LEVEL0_LOW_ADDR = 20'hFFFE8;
    localparam logic [ADDR_W-1:0] PRIORITY_LEVEL0_HIGH_ADDR = 20'hFFFE9;
    localparam logic [ADDR_W-1:0] PRIORITY_LEVEL1_LOW_ADDR = 20'hFFFEC;
    localparam logic [ADDR_W-1:0] PRIORITY_LEVEL1_HIGH_ADDR = 20'hFFFED;
    // Status word window on the register port.
    localparam logic [ADDR_W-1:0] PROGRAM_STATUS_WORD_ADDR = 20'hFFFF0;

    localparam logic [7:0] PRIORITY_RESET = 8'hFF;
    localparam logic [7:0] PSW_RESET = 8'h06;
    localparam logic [7:0] PUSH_FILL_BYTE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field positions inside the status word.
    localparam int PSW_IE_BIT = 7;
    localparam int PSW_IN_SERVICE_LEVEL_BIT0_BIT = 1;
    localparam int PSW_IN_SERVICE_LEVEL_BIT1_BIT = 2;

    // Stack pointer adjustments.
    localparam logic [ADDR_W-1:0] SP_ONE = 20'h00001;
    localparam logic [ADDR_W-1:0] SP_TWO = 20'h00002;

    // Clocks taken by the pop-status-word instruction.
    localparam int POP_CLOCKS = 3;

    typedef enum logic [4:0] {
        IPSW_IDLE = 5'b00001,
        IPSW_PUSH_LO = 5'b00010,
        IPSW_POP_RD = 5'b00100,
        IPSW_POP_LD = 5'b01000,
        IPSW_SAVE_DONE = 5'b10000
    } ipsw_state_e;

    // One-cycle instruction strobes from the core's sequencer.
    typedef struct packed {
        logic enable_irq_instruction;
        logic disable_irq_instruction;
        logic psw_write;
        logic [7:0] psw_wdata;
        logic bit_write;
        logic [2:0] bit_index;
        logic bit_value;
        logic push_status_instruction;
        logic pop_status_instruction;
        logic break_instruction;
        logic maskable_accept;
        logic vectored_accept;
        logic status_restore;
        logic [7:0] restore_data;
    } ipsw_cmd_s;

    // Byte access toward stack memory.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } ipsw_stack_s;

endpackage

/* src/ipsw_src_level.sv */
// Per-source priority level and eligibility check.
// Assumes the request line is already in the sys_clk domain.
`timescale 1ns/1ps
module ipsw_src_level
    import ipsw_pkg::*;
(
    input wire logic req,
    input wire logic prio_bit0,
    input wire logic prio_bit1,
    input wire logic irq_enable,
    input wire logic [1:0] in_service_level,
    output logic [1:0] level,
    output logic eligible
);

    // Level 0 is the highest priority, level 3 the lowest.
    assign level = {prio_bit1, prio_bit0}; // R1
    assign eligible = req && irq_enable && (level < in_service_level); // R11

endmodule // ipsw_src_level

/* verification/ipsw_core_checker.sv */
// Concurrent checks on the status-word block, bound to its top module.
// Assumes the core issues stack commands only while busy is low.
`timescale 1ns/1ps
module ipsw_core_checker
    import ipsw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire ipsw_cmd_s cmd,
    input wire logic [ADDR_W-1:0] stack_pointer,
    input wire logic [7:0] stack_rdata,
    input wire ipsw_stack_s stack_access,
    input wire logic sp_load,
    input wire logic [ADDR_W-1:0] sp_next,
    input wire logic [7:0] program_status_word,
    input wire logic irq_pending,
    input wire logic [1:0] irq_level,
    input wire logic busy,
    input wire logic done
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_reset_psw: assert property ($rose(reset_n) |-> program_status_word == PSW_RESET)
        else $error("status word wrong after reset");
    a_enable_sets: assert property (cmd.enable_irq_instruction && !busy |=>
        program_status_word[PSW_IE_BIT]) else $error("enable flag not set");
    a_accept_level: assert property (cmd.maskable_accept && irq_pending && !busy |=>
        !program_status_word[PSW_IE_BIT] && program_status_word[2:1] == $past(irq_level))
        else $error("accept did not load in-service level");
    a_break_save: assert property (cmd.break_instruction && !busy |=>
        !program_status_word[PSW_IE_BIT] && stack_access.wr
        && stack_access.wdata == $past(program_status_word)) else $error("break save wrong");
    a_push_seq: assert property (cmd.push_status_instruction && !busy |=>
        stack_access.wr && stack_access.addr == $past(stack_pointer) - SP_ONE
        && stack_access.wdata == $past(program_status_word) ##1 stack_access.wr
        && stack_access.wdata == PUSH_FILL_BYTE && sp_load
        && sp_next == $past(stack_pointer, 2) - SP_TWO) else $error("push sequence wrong");
    a_pop_seq: assert property (cmd.pop_status_instruction && !busy |=> busy
        ##1 stack_access.rd && stack_access.addr == $past(stack_pointer, 2) + SP_ONE
        ##1 sp_load && done && sp_next == $past(stack_pointer, 3) + SP_TWO
        && program_status_word == $past(stack_rdata)) else $error("pop sequence wrong");
    a_restore_load: assert property (cmd.status_restore && !busy |=>
        program_status_word == $past(cmd.restore_data)) else $error("restore not loaded");
    a_offer_rule: assert property (irq_pending && $stable(program_status_word) |->
        program_status_word[PSW_IE_BIT] && irq_level < program_status_word[2:1])
        else $error("request offered against enable or level");
endmodule // ipsw_core_checker

bind ipsw_core ipsw_core_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .cmd(cmd),
    .stack_pointer(stack_pointer), .stack_rdata(stack_rdata), .stack_access(stack_access),
    .sp_load(sp_load), .sp_next(sp_next), .program_status_word(program_status_word),
    .irq_pending(irq_pending), .irq_level(irq_level), .busy(busy), .done(done));

/* verification/ipsw_core_model.sv */
// Core-side model: stack pointer and stack memory.
// Assumes stack reads are answered combinationally in the cycle of the read strobe.
`timescale 1ns/1ps
module ipsw_core_model
    import ipsw_pkg::*;
#(
    parameter logic [ADDR_W-1:0] SP_INIT = 20'h00100
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire ipsw_stack_s stack_access,
    input wire logic sp_load,
    input wire logic [ADDR_W-1:0] sp_next,
    output logic [ADDR_W-1:0] stack_pointer,
    output logic [7:0] stack_rdata
);
    logic [7:0] mem [256];
    logic [7:0] last_q;

    // An unselected read bus shows the inverse of the last byte, never a stale copy.
    assign stack_rdata = stack_access.rd ? mem[stack_access.addr[7:0]] : ~last_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_pointer <= SP_INIT;
            last_q <= 8'h00;
        end else begin
            if (sp_load) stack_pointer <= sp_next;
            if (stack_access.wr) mem[stack_access.addr[7:0]] <= stack_access.wdata;
            if (stack_access.rd) last_q <= stack_rdata;
        end
    end
endmodule // ipsw_core_model

/* verification/tb.sv */
// Self-checking bench for the status-word block with a core model on the stack side.
// Assumes the model starts the stack pointer at 00100.
`timescale 1ns/1ps
module tb
    import ipsw_pkg::*;
;
    logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0, stack_pointer, sp_next;
    logic [7:0] reg_wdata = '0, reg_rdata, stack_rdata, program_status_word;
    logic [NUM_SRC-1:0] irq_req = '0;
    ipsw_cmd_s cmd = '0;
    ipsw_stack_s stack_access;
    logic sp_load, irq_pending, busy, done;
    logic [SRC_W-1:0] irq_source;
    logic [1:0] irq_level;
    logic [19:0] pr_addr [4] = '{PRIORITY_LEVEL0_LOW_ADDR, PRIORITY_LEVEL0_HIGH_ADDR,
        PRIORITY_LEVEL1_LOW_ADDR, PRIORITY_LEVEL1_HIGH_ADDR};
    logic [7:0] pr_val [4] = '{8'hFF, 8'hFD, 8'hF7, 8'hFD};
    int errors = 0, checks = 0;

    always #4 sys_clk = ~sys_clk;

    ipsw_core uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_req(irq_req), .cmd(cmd), .stack_pointer(stack_pointer),
        .stack_rdata(stack_rdata), .stack_access(stack_access), .sp_load(sp_load),
        .sp_next(sp_next), .program_status_word(program_status_word),
        .irq_pending(irq_pending), .irq_source(irq_source), .irq_level(irq_level),
        .busy(busy), .done(done));
    ipsw_core_model partner (.sys_clk(sys_clk), .reset_n(reset_n), .stack_access(stack_access),
        .sp_load(sp_load), .sp_next(sp_next), .stack_pointer(stack_pointer),
        .stack_rdata(stack_rdata));

    task conclude;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task check(input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task bus_write(input logic [19:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task bus_read(input logic [19:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        check(reg_rdata, exp);
    endtask

    // Codes 0-9: enable, disable, write, bit 7 write, push, pop, break, accept, vectored, restore.
    function automatic ipsw_cmd_s mkc(input int k, input logic [7:0] v);
        mkc = '0;
        mkc.psw_wdata = v;
        mkc.restore_data = v;
        mkc.bit_index = 3'h7;
        mkc.bit_value = v[0];
        case (k)
            0: mkc.enable_irq_instruction = 1'b1;
            1: mkc.disable_irq_instruction = 1'b1;
            2: mkc.psw_write = 1'b1;
            3: mkc.bit_write = 1'b1;
            4: mkc.push_status_instruction = 1'b1;
            5: mkc.pop_status_instruction = 1'b1;
            6: mkc.break_instruction = 1'b1;
            7: mkc.maskable_accept = 1'b1;
            8: mkc.vectored_accept = 1'b1;
            default: mkc.status_restore = 1'b1;
        endcase
    endfunction

    task go(input int k, input logic [7:0] v, input logic [7:0] exp);
        @(posedge sys_clk);
        cmd <= mkc(k, v);
        @(posedge sys_clk);
        cmd <= '0;
        @(negedge sys_clk);
        for (int n = 0; n < 8 && k >= 4 && k <= 8 && done !== 1'b1; n++) @(negedge sys_clk);
        if (k >= 4 && k <= 8) check(done, 1'b1);
        // The model applies the last stack write and the new stack pointer one edge after done.
        @(negedge sys_clk);
        check(program_status_word, exp);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) bus_read(pr_addr[i], PRIORITY_RESET);
        bus_read(PROGRAM_STATUS_WORD_ADDR, PSW_RESET);
        bus_write(PROGRAM_STATUS_WORD_ADDR, 8'h55);
        bus_read(PROGRAM_STATUS_WORD_ADDR, PSW_RESET);
        bus_read(20'hFFFE0, UNMAPPED_READ);
        for (int i = 0; i < 4; i++) bus_write(pr_addr[i], pr_val[i]);
        for (int i = 0; i < 4; i++) bus_read(pr_addr[i], pr_val[i]);
        // Source 3 at level 1 and source 9 at level 0; level 0 must win.
        @(posedge sys_clk);
        irq_req <= 16'h0208;
        repeat (6) @(negedge sys_clk);
        check(irq_pending, 1'b0);
        go(0, 8'h00, 8'h86);
        for (int n = 0; n < 8 && irq_pending !== 1'b1; n++) @(negedge sys_clk);
        check({irq_pending, irq_source, irq_level}, {1'b1, 4'h9, 2'h0});
        go(7, 8'h00, 8'h00);
        check(partner.mem[8'hFF], 8'h86);
        // In-service level 0 now blocks both requests although interrupts are enabled.
        go(0, 8'h00, 8'h80);
        repeat (3) @(negedge sys_clk);
        check(irq_pending, 1'b0);
        @(posedge sys_clk);
        irq_req <= '0;
        go(2, 8'h5A, 8'h5A);
        bus_read(PROGRAM_STATUS_WORD_ADDR, 8'h5A);
        go(3, 8'h01, 8'hDA);
        go(4, 8'h00, 8'hDA);
        check({partner.mem[8'hFF], partner.mem[8'hFE]}, 16'hDA00);
        check(stack_pointer, 20'h000FE);
        go(1, 8'h00, 8'h5A);
        go(5, 8'h00, 8'hDA);
        check(stack_pointer, 20'h00100);
        go(2, 8'h9E, 8'h9E);
        go(6, 8'h00, 8'h1E);
        check(partner.mem[8'hFF], 8'h9E);
        go(2, 8'hC4, 8'hC4);
        go(8, 8'h00, 8'h44);
        check(partner.mem[8'hFF], 8'hC4);
        go(9, 8'h84, 8'h84);
        conclude();
    end

    // The sequence takes about 100 cycles; 20 us leaves a wide margin.
    initial begin
        #20000;
        errors++;
        conclude();
    end
endmodule // tb
